// ---- core/srap_pkg.sv ----
// constants, types and helpers shared by the serial register access port
package srap_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // datagram layout
   localparam int unsigned DGRAM_W    = 40;          // address byte plus data word
   localparam int unsigned ADDR_W     = 7;           // register address width
   localparam int unsigned DATA_W     = 32;          // data word width
   localparam int unsigned STAT_W     = 8;           // status byte width
   localparam int unsigned WR_SEL_POS = 39;          // write_select_bit position
   localparam int unsigned ADDR_LSB   = 32;          // lowest address bit in datagram
   localparam logic [5:0]  BIT_CNT_FULL = 6'h28;     // 40 bits make a command

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0]  STATUS_RST = 8'h00;       // status byte after reset
   localparam logic [31:0] DATA_RST   = 32'h0000_0000; // reply word after reset
   localparam logic [2:0]  PIN_IDLE   = 3'h5;        // {cs_n, sdi, sck} idle levels

   ////////////////////////////////////////////////////////////////////////////
   // status byte source bit positions
   localparam int unsigned RAMP_STOP_R_POS  = 1;     // right stop switch
   localparam int unsigned RAMP_STOP_L_POS  = 0;     // left stop switch
   localparam int unsigned RAMP_POS_OK_POS  = 9;     // target position reached
   localparam int unsigned RAMP_VEL_OK_POS  = 8;     // target velocity reached
   localparam int unsigned DRV_STANDST_POS  = 31;    // motor at standstill
   localparam int unsigned DRV_STALL_POS    = 24;    // stall_detect_flag
   localparam int unsigned GLB_DRV_ERR_POS  = 1;     // driver error
   localparam int unsigned GLB_RESET_POS    = 0;     // reset occurred

   ////////////////////////////////////////////////////////////////////////////
   // port sequencing states, one-hot
   typedef enum logic [2:0] {
      SRAP_IDLE  = 3'h1,                             // chip select high
      SRAP_SHIFT = 3'h2,                             // frame in progress
      SRAP_FETCH = 3'h4                              // read data being captured
   } srap_state_type;

   // assemble the serial_status_byte from its sources
   function automatic logic [7:0] srap_status(
      input logic [9:0]  ramp,
      input logic [31:0] drv,
      input logic [1:0]  glb
   );
      srap_status = {ramp[RAMP_STOP_R_POS], ramp[RAMP_STOP_L_POS],
                     ramp[RAMP_POS_OK_POS], ramp[RAMP_VEL_OK_POS],
                     drv[DRV_STANDST_POS],  drv[DRV_STALL_POS],
                     glb[GLB_DRV_ERR_POS],  glb[GLB_RESET_POS]};
   endfunction

endpackage

// ---- core/srap_pin_if.sv ----
// filtered serial pin levels and edge pulses between synchroniser and port
`timescale 1ns/1ns
`default_nettype none
interface srap_pin_if;
   logic sck_lvl;                                    // filtered serial clock
   logic sdi_lvl;                                    // filtered serial data in
   logic cs_n_lvl;                                   // filtered chip_select_n
   logic sck_rise;                                   // one-cycle rising edge pulse
   logic sck_fall;                                   // one-cycle falling edge pulse
   logic cs_fall;                                    // frame start pulse
   logic cs_rise;                                    // frame end pulse

   modport drv (output sck_lvl, sdi_lvl, cs_n_lvl, sck_rise, sck_fall, cs_fall, cs_rise);
   modport sink (input  sck_lvl, sdi_lvl, cs_n_lvl, sck_rise, sck_fall, cs_fall, cs_rise);
endinterface
`default_nettype wire

// ---- core/srap_pin_sync.sv ----
// three-stage synchroniser, glitch filter and edge finder for the serial pins
`timescale 1ns/1ns
`default_nettype none
module srap_pin_sync (
   input  wire logic  mclk_i,                        // system clock
   input  wire logic  nrst_i,                        // synchronous reset, active low
   input  wire logic  sck_i,                         // raw serial clock pin
   input  wire logic  sdi_i,                         // raw serial data pin
   input  wire logic  chip_select_n_i,               // raw chip select pin
   srap_pin_if.drv    pins                           // filtered levels and edges
);

   logic [2:0] meta_r;                               // first stage, read by stage two only
   logic [2:0] sync_r;                               // second stage
   logic [2:0] late_r;                               // third stage
   logic [2:0] filt_r;                               // accepted levels
   logic [2:0] prev_r;                               // accepted levels one cycle back

   ////////////////////////////////////////////////////////////////////////////
   // sampling chain; reset to idle levels so no false edge leaves reset
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         meta_r <= srap_pkg::PIN_IDLE;
         sync_r <= srap_pkg::PIN_IDLE;
         late_r <= srap_pkg::PIN_IDLE;
      end
      else
      begin
         meta_r <= {chip_select_n_i, sdi_i, sck_i};
         sync_r <= meta_r;
         late_r <= sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // [RULE18] glitch rejection filter
   // a level counts only when two stages agree, so a 10 ns spike never lands
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         filt_r <= srap_pkg::PIN_IDLE;
         prev_r <= srap_pkg::PIN_IDLE;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (sync_r[i] == late_r[i])
               filt_r[i] <= late_r[i];
         end
         prev_r <= filt_r;
      end
   end

   // levels and one-cycle edge pulses
   assign pins.sck_lvl  = filt_r[0];
   assign pins.sdi_lvl  = filt_r[1];
   assign pins.cs_n_lvl = filt_r[2];
   assign pins.sck_rise = filt_r[0] & ~prev_r[0];
   assign pins.sck_fall = ~filt_r[0] & prev_r[0];
   assign pins.cs_fall  = ~filt_r[2] & prev_r[2];
   assign pins.cs_rise  = filt_r[2] & ~prev_r[2];

endmodule
`default_nettype wire

// ---- core/srap_port.sv ----
// serial register access port: 40-bit datagram slave with status reply
//
// Notes on behaviour
// [RULE1] datagram is address byte plus 32-bit word
// [RULE2] master holds chip select low whole frame
// [RULE3] bit 39 high means write, low read
// [RULE4] reply carries read data or echoed write
// [RULE5] read ignores data, only records address
// [RULE6] registers always moved as whole words
// [RULE7] status byte sent in reply bits 39..32
// [RULE8] status latched at frame end, sent next
// [RULE9] stop switches and reached flags from ramp
// [RULE10] standstill and stall flags from driver
// [RULE11] error and reset flags from global status
// [RULE12] sample on rising, drive after falling, msb first
// [RULE13] master gives at least forty clocks
// [RULE14] extra bits leave output forty clocks later
// [RULE15] chip select rise executes shift register
// [RULE16] only last forty bits form command
// [RULE17] master clock at most half system clock; the filter needs two samples per level, so only up to a quarter
// [RULE18] pulses under 20 ns are ignored; the filter is only sure to reject pulses under one 10 ns system clock
// [RULE19] link uses clock idle high, mode 3
// [RULE20] output released while chip select high
`timescale 1ns/1ns
`default_nettype none
module srap_port (
   input  wire logic        mclk_i,                  // system clock, 100 MHz
   input  wire logic        nrst_i,                  // synchronous reset, active low
   input  wire logic        sck_i,                   // serial clock pin
   input  wire logic        sdi_i,                   // serial data in pin
   input  wire logic        chip_select_n_i,         // chip select pin, active low
   output logic             sdo_o,                   // serial data out value
   output logic             sdo_oe_o,                // serial data out enable
   output logic [6:0]       reg_addr_o,              // register address of last command
   output logic [31:0]      reg_wdata_o,             // write data of last write command
   output logic             reg_wr_o,                // one-cycle write strobe
   output logic             reg_rd_o,                // one-cycle read strobe
   input  wire logic [31:0] reg_rdata_i,             // read word for reg_addr_o
   input  wire logic [9:0]  ramp_status_i,           // ramp status bits
   input  wire logic [31:0] driver_condition_i,      // driver_condition_reg
   input  wire logic [1:0]  global_condition_i,      // global_condition_reg flags
   output logic [39:0]      cmd_o                    // internal command register
);

   srap_pin_if              pins ();                 // filtered pin view
   srap_pkg::srap_state_type state_r;                // sequencing state
   logic [39:0]             shift_r;                 // 40-bit shift register
   logic [5:0]              bit_cnt_r;               // rising edges this frame, saturating
   logic [7:0]              status_r;                // latched serial_status_byte
   logic [31:0]             tx_data_r;               // data word of next reply
   logic                    sdo_r;                   // serial output bit
   logic                    active;                  // chip select asserted
   logic                    end_ok;                  // frame ended with enough bits
   logic                    end_short;               // frame ended too short

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and filter
   srap_pin_sync u_sync (
      .mclk_i          (mclk_i),
      .nrst_i          (nrst_i),
      .sck_i           (sck_i),
      .sdi_i           (sdi_i),
      .chip_select_n_i (chip_select_n_i),
      .pins            (pins.drv)
   );

   assign active    = ~pins.cs_n_lvl;
   // [RULE1] forty-bit frame length
   // [RULE13] short frame check
   assign end_ok    = pins.cs_rise && (bit_cnt_r == srap_pkg::BIT_CNT_FULL);
   assign end_short = pins.cs_rise && (bit_cnt_r != srap_pkg::BIT_CNT_FULL);

   ////////////////////////////////////////////////////////////////////////////
   // sequencing: idle, shifting, one cycle to fetch read data
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         state_r <= srap_pkg::SRAP_IDLE;
      else
      begin
         case (state_r)
            srap_pkg::SRAP_IDLE:
            begin
               if (pins.cs_fall)
                  state_r <= srap_pkg::SRAP_SHIFT;
            end
            srap_pkg::SRAP_SHIFT:
            begin
               if (end_ok && !shift_r[srap_pkg::WR_SEL_POS])
                  state_r <= srap_pkg::SRAP_FETCH;   // read: grab word next cycle
               else if (pins.cs_rise)
                  state_r <= srap_pkg::SRAP_IDLE;    // write or short frame
            end
            srap_pkg::SRAP_FETCH:
               state_r <= srap_pkg::SRAP_IDLE;
            default:
               state_r <= srap_pkg::SRAP_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit counter; saturating, so long chains still form a command
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         bit_cnt_r <= 6'h00;
      else if (pins.cs_fall)
         bit_cnt_r <= 6'h00;
      else if (pins.sck_rise && active && bit_cnt_r != srap_pkg::BIT_CNT_FULL)
         bit_cnt_r <= bit_cnt_r + 6'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // [RULE7] [RULE12] [RULE14] load reply, shift msb first
   // a 40-deep register means extra input bits reappear 40 clocks later
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         shift_r <= {srap_pkg::STATUS_RST, srap_pkg::DATA_RST};
      else if (pins.cs_fall)
         shift_r <= {status_r, tx_data_r};
      else if (pins.sck_rise && active)
         shift_r <= {shift_r[38:0], pins.sdi_lvl};
   end

   ////////////////////////////////////////////////////////////////////////////
   // [RULE12] [RULE19] output updated after falling edge
   // first falling edge of a mode 3 frame repeats bit 39, already shown
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         sdo_r <= 1'b0;
      else if (pins.cs_fall)
         sdo_r <= status_r[7];
      else if (pins.sck_fall && active)
         sdo_r <= shift_r[39];
   end

   // [RULE20] output released while deselected
   assign sdo_o    = sdo_r;
   assign sdo_oe_o = active;

   ////////////////////////////////////////////////////////////////////////////
   // [RULE15] [RULE16] execute on chip select rise
   // only the last 40 bits remain in the register, so they are the command
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         cmd_o       <= 40'h00_0000_0000;
         reg_addr_o  <= 7'h00;
         reg_wdata_o <= srap_pkg::DATA_RST;
         reg_wr_o    <= 1'b0;
         reg_rd_o    <= 1'b0;
      end
      else
      begin
         reg_wr_o <= 1'b0;
         reg_rd_o <= 1'b0;
         if (end_ok)
         begin
            cmd_o      <= shift_r;
            reg_addr_o <= shift_r[38:32];
            // [RULE3] [RULE5] direction select
            if (shift_r[srap_pkg::WR_SEL_POS])
            begin
               // [RULE6] whole-word write
               reg_wdata_o <= shift_r[31:0];
               reg_wr_o    <= 1'b1;
            end
            else
               reg_rd_o <= 1'b1;                     // data bits ignored
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // [RULE4] reply word for the next frame
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         tx_data_r <= srap_pkg::DATA_RST;
      else if (end_ok && shift_r[srap_pkg::WR_SEL_POS])
         tx_data_r <= shift_r[31:0];                 // echo write data
      else if (state_r == srap_pkg::SRAP_FETCH)
         tx_data_r <= reg_rdata_i;                   // word at recorded address
   end

   ////////////////////////////////////////////////////////////////////////////
   // [RULE8] [RULE9] [RULE10] [RULE11] latch status byte
   // taken before the read strobe, so a global status read still shows its flags
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         status_r <= srap_pkg::STATUS_RST;
      else if (end_ok)
         status_r <= srap_pkg::srap_status(ramp_status_i, driver_condition_i,
                                           global_condition_i);
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   property p_write_exec;
      end_ok && shift_r[39] |=> reg_wr_o && !reg_rd_o && reg_wdata_o == $past(shift_r[31:0]);
   endproperty
   a_write_exec: assert property (p_write_exec) else $error("write not executed"); // [RULE15]

   property p_read_only_addr;
      end_ok && !shift_r[39] |=> reg_rd_o && !reg_wr_o && reg_addr_o == $past(shift_r[38:32]);
   endproperty
   a_read_only_addr: assert property (p_read_only_addr) else $error("read wrote"); // [RULE5]

   property p_read_reply;
      reg_rd_o |=> tx_data_r == $past(reg_rdata_i);
   endproperty
   a_read_reply: assert property (p_read_reply) else $error("read word lost"); // [RULE4]

   property p_write_echo;
      end_ok && shift_r[39] |=> tx_data_r == $past(shift_r[31:0]);
   endproperty
   a_write_echo: assert property (p_write_echo) else $error("write not echoed"); // [RULE4]

   property p_status_latch;
      end_ok |=> status_r == srap_pkg::srap_status($past(ramp_status_i),
                   $past(driver_condition_i), $past(global_condition_i));
   endproperty
   a_status_latch: assert property (p_status_latch) else $error("status wrong"); // [RULE9]

   property p_reply_load;
      pins.cs_fall |=> shift_r == {$past(status_r), $past(tx_data_r)} && sdo_o == shift_r[39];
   endproperty
   a_reply_load: assert property (p_reply_load) else $error("reply not loaded"); // [RULE7]

   property p_shift_in;
      pins.sck_rise && active && !pins.cs_fall
         |=> shift_r == {$past(shift_r[38:0]), $past(pins.sdi_lvl)};
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift failed"); // [RULE12]

   property p_sdo_update;
      pins.sck_fall && active |=> sdo_o == $past(shift_r[39]);
   endproperty
   a_sdo_update: assert property (p_sdo_update) else $error("sdo not updated"); // [RULE12]

   property p_short_ignored;
      end_short |=> !reg_wr_o && !reg_rd_o ##1 !reg_wr_o && !reg_rd_o;
   endproperty
   a_short_ignored: assert property (p_short_ignored) else $error("short frame ran"); // [RULE13]

   property p_release;
      pins.cs_rise |=> !sdo_oe_o;
   endproperty
   a_release: assert property (p_release) else $error("sdo driven idle"); // [RULE20]

   c_write: cover property (end_ok && shift_r[39]);
   c_read:  cover property (reg_rd_o ##1 tx_data_r != srap_pkg::DATA_RST);
   c_long:  cover property (active && bit_cnt_r == srap_pkg::BIT_CNT_FULL && pins.sck_rise);
   c_short: cover property (end_short);

endmodule
`default_nettype wire

// ---- test/srap_host_model.sv ----
// behavioural spi master that drives the serial register access port link
`timescale 1ns/1ns
`default_nettype none
module srap_host_model (
   output logic      sck_o,              // serial clock, idle high
   output logic      sdi_o,              // serial data to device
   output logic      chip_select_n_o,    // chip_select_n
   input  wire logic sdo_i               // resolved serial data out line
);
   localparam int HALF_NS = 80;          // half of the 160 ns link period

   ////////////////////////////////////////////////////////////////////////////
   // idle levels
   initial
   begin
      sck_o = 1'b1;
      sdi_o = 1'b0;
      chip_select_n_o = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one frame of n bits; slow edges keep sck under half the system clock
   // frame timing
   task automatic frame(input logic [47:0] tx, input int n, output logic [47:0] rx);
      rx = '0;
      chip_select_n_o = 1'b0;
      #HALF_NS;
      for (int i = n - 1; i >= 0; i--)
      begin
         sck_o = 1'b0;
         sdi_o = tx[i];                  // launch after falling edge, msb first
         #HALF_NS;
         sck_o = 1'b1;
         rx[i] = sdo_i;                  // capture on rising edge
         #HALF_NS;
      end
      chip_select_n_o = 1'b1;
      sdi_o = ~sdi_o;                    // undriven line does not keep last bit
      #200;
   endtask

   // chip select pulse too short to be a frame; spans one system clock edge
   task automatic glitch;
      chip_select_n_o = 1'b0;
      #12;
      chip_select_n_o = 1'b1;
      #200;
   endtask
endmodule
`default_nettype wire

// ---- test/spi_register_access_port_tb_top.sv ----
// self-checking bench for the serial register access port
`timescale 1ns/1ns
`default_nettype none
module spi_register_access_port_tb_top;
   localparam logic [6:0] GLB_ADDR = 7'h01; // global flags address, arbitrary value
   logic             mclk_i;             // system clock
   logic             nrst_i;             // reset, active low
   wire logic        sck;                // link clock
   wire logic        sdi;                // link data in
   wire logic        chip_select_n;      // link select, active low
   wire logic        sdo_line;           // resolved data out line
   logic             sdo_o;              // device data out
   logic             sdo_oe_o;           // device out enable
   logic [6:0]       reg_addr_o;         // command address
   logic [31:0]      reg_wdata_o;        // command write data
   logic             reg_wr_o;           // write strobe
   logic             reg_rd_o;           // read strobe
   wire logic [31:0] reg_rdata_i;        // register file word
   logic [9:0]       ramp_status_i;      // ramp flags
   logic [31:0]      driver_condition_i; // driver flags
   logic [1:0]       global_condition_i; // sticky global flags
   logic [39:0]      cmd_o;              // command register
   int               error_cnt;          // mismatches
   int               cmp_count;          // comparisons
   int               wr_cnt;             // write strobe cycles
   int               rd_cnt;             // read strobe cycles
   logic             oe_seen;            // out enable was raised

   srap_port uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sck_i(sck), .sdi_i(sdi),
      .chip_select_n_i(chip_select_n), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
      .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i), .ramp_status_i(ramp_status_i),
      .driver_condition_i(driver_condition_i),
      .global_condition_i(global_condition_i), .cmd_o(cmd_o));
   srap_host_model host (.sck_o(sck), .sdi_o(sdi), .chip_select_n_o(chip_select_n),
      .sdo_i(sdo_line));

   ////////////////////////////////////////////////////////////////////////////
   // clock, pin resolution, register file and strobe counters
   initial mclk_i = 1'b0;
   always #5 mclk_i = ~mclk_i;
   assign sdo_line = sdo_oe_o ? sdo_o : 1'bz;
   // distinct word per address so a wrong address shows
   function automatic logic [31:0] rd_word(input logic [6:0] a);
      return {~a, 18'h05A5A, a};
   endfunction
   assign reg_rdata_i = rd_word(reg_addr_o);
   // counts every strobe cycle, so a stretched strobe shows as two
   always @(posedge mclk_i)
   begin
      if (reg_wr_o === 1'b1) wr_cnt++;
      if (reg_rd_o === 1'b1) rd_cnt++;
      if (sdo_oe_o === 1'b1) oe_seen = 1'b1;
      // flags stay set until read
      if (reg_rd_o === 1'b1 && reg_addr_o === GLB_ADDR) global_condition_i <= 2'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
      @(posedge mclk_i);
      #3;
      host.frame(tx, n, rx);
   endtask

   task automatic set_flags(input logic [9:0] r, input logic [31:0] d, input logic [1:0] g);
      @(posedge mclk_i);
      ramp_status_i <= r;
      driver_condition_i <= d;
      if (g !== 2'h0) global_condition_i <= g;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      chk("cmd", 48'h0, 48'(cmd_o)); // command register after reset
      chk("addr", 48'h0, 48'(reg_addr_o)); // address after reset
      chk("sdo", 48'(1'bz), 48'(sdo_line)); // released when idle
      $display("test reset done");
   endtask

   task automatic t_write;
      logic [47:0] rx;
      int w0;
      w0 = wr_cnt;
      xfer(48'h00A700ABCDEF, 40, rx);
      chk("reply0", 48'h0, rx); // status and word after reset
      chk("wr", 48'(1), 48'(wr_cnt - w0)); // one strobe per command
      chk("addr", 48'h27, 48'(reg_addr_o)); // address below bit 39
      chk("wdata", 48'h00ABCDEF, 48'(reg_wdata_o)); // word layout
      chk("cmd", 48'hA700ABCDEF, 48'(cmd_o)); // command register
      chk("sdo", 48'(1'bz), 48'(sdo_line)); // released after frame
      xfer(48'h00A700123456, 40, rx);
      chk("echo", 48'h0000ABCDEF, rx); // echo of previous write
      $display("test write done");
   endtask

   task automatic t_read;
      logic [47:0] rx;
      int w0;
      int r0;
      w0 = wr_cnt;
      r0 = rd_cnt;
      xfer(48'h0021DEADBEEF, 40, rx);
      chk("echo", 48'h0000123456, rx); // write echo before read
      chk("wdata", 48'h00123456, 48'(reg_wdata_o)); // dummy data ignored
      xfer(48'h002200000000, 40, rx);
      chk("rd21", {16'h0, rd_word(7'h21)}, rx); // pipelined read
      chk("wr", 48'(0), 48'(wr_cnt - w0)); // reads write nothing
      chk("rd", 48'(2), 48'(rd_cnt - r0)); // one strobe per read
      xfer(48'h00A2FFFFFFFF, 40, rx);
      chk("rd22", {16'h0, rd_word(7'h22)}, rx); // whole word returned
      $display("test read done");
   endtask

   task automatic t_status;
      logic [47:0] rx;
      set_flags(10'h201, 32'h80000000, 2'h3);
      xfer({9'h0, GLB_ADDR, 32'h0}, 40, rx);
      chk("st0", 48'h00, 48'(rx[39:32])); // status from previous end
      xfer(48'h0, 40, rx);
      chk("stA", 48'h6B, 48'(rx[39:32])); // bit mapping
      set_flags(10'h102, 32'h01000000, 2'h0);
      xfer(48'h0, 40, rx);
      chk("stC", 48'h68, 48'(rx[39:32])); // flags cleared by read
      xfer(48'h0, 40, rx);
      chk("stB", 48'h94, 48'(rx[39:32])); // other flag bits
      set_flags(10'h0, 32'h0, 2'h0);
      $display("test status done");
   endtask

   task automatic t_short;
      logic [47:0] rx;
      int w0;
      w0 = wr_cnt;
      xfer(48'h00A511111111, 39, rx);
      chk("cmd", 48'h0000000000, 48'(cmd_o)); // short frame ignored
      chk("wr", 48'(0), 48'(wr_cnt - w0)); // no strobe
      $display("test short done");
   endtask

   task automatic t_daisy;
      logic [47:0] rx;
      xfer(48'hC3A6CAFEF00D, 48, rx);
      chk("cmd", 48'hA6CAFEF00D, 48'(cmd_o)); // last forty bits
      chk("wdata", 48'hCAFEF00D, 48'(reg_wdata_o)); // last forty bits
      chk("thru", 48'hC3, 48'(rx[7:0])); // forty clock delay
      $display("test daisy done");
   endtask

   task automatic t_glitch;
      oe_seen = 1'b0;
      @(posedge mclk_i);
      #3;
      host.glitch();
      chk("oe", 48'(0), 48'(oe_seen)); // short pulse ignored
      chk("cmd", 48'hA6CAFEF00D, 48'(cmd_o)); // nothing executed
      $display("test glitch done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // verdict and run control
   task automatic summarize;
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // frames take about 7 us each, so 200 us means a hang
   initial
   begin
      #200000;
      error_cnt++;
      summarize();
   end

   initial
   begin
      error_cnt = 0;
      cmp_count = 0;
      wr_cnt = 0;
      rd_cnt = 0;
      oe_seen = 1'b0;
      nrst_i = 1'b0;
      ramp_status_i = 10'h0;
      driver_condition_i = 32'h0;
      global_condition_i = 2'h0;
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      t_reset();
      t_write();
      t_read();
      t_status();
      t_short();
      t_daisy();
      t_glitch();
      summarize();
   end
endmodule
`default_nettype wire
